// file: verilog/video_output_genlock.sv
`timescale 1ns/1ps
`default_nettype none
module video_output_genlock #(
   parameter int DIV_W = 16,
   parameter int POS_W = 16,
   parameter int LOCK_PULSES = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mezzanine_clock_input,
   input wire logic ref_vid_tick,
   input wire logic ref_sof,
   output logic osc_speed_up,
   output logic osc_slow_down,
   output logic out_vid_en,
   output logic out_sof,
   output logic out_line_start,
   output logic sample_repeat,
   output logic sample_remove,
   output logic frame_locked
);
   if (DIV_W < 2 || DIV_W > 16 || POS_W < 2 || POS_W > 16) begin : g_chk_w
      $error("DIV_W and POS_W must lie in 2..16");
   end
   if (LOCK_PULSES < 1 || LOCK_PULSES > 255) begin : g_chk_lock
      $error("LOCK_PULSES must lie in 1..255");
   end

   logic [genlock_pkg::CTRL_W-1:0] ctrl_ff;
   logic [DIV_W-1:0] ref_div_ff;
   logic [DIV_W-1:0] osc_div_ff;
   logic [POS_W-1:0] width_ff;
   logic [POS_W-1:0] height_ff;
   logic [POS_W-1:0] sof_x_ff;
   logic [POS_W-1:0] sof_y_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [3:0] acc_ff;
   logic vid_en_ff;
   logic up_ff;
   logic dn_ff;
   logic [7:0] err_cnt_ff;
   logic [7:0] lock_cnt_ff;
   logic [POS_W-1:0] x_ff;
   logic [POS_W-1:0] y_ff;
   logic sof_ff;
   logic line_ff;
   logic ref_sof_d_ff;
   logic rep_ff;
   logic rem_ff;
   logic aligned_ff;
   logic locked_ff;
   logic [POS_W:0] offs_x_ff;
   logic [POS_W:0] offs_y_ff;
   genlock_pkg::lock_state_t state_ff;
   genlock_pkg::lock_state_t nxt_state;

   logic en;
   logic frm_allow;
   logic [1:0] rate;
   logic [3:0] num;
   logic [3:0] den;
   logic [4:0] acc_sum;
   logic ref_pulse;
   logic osc_pulse;
   logic good_evt;
   logic clk_locked;
   logic ref_edge;
   logic frm_active;
   logic [POS_W:0] dx;
   logic [POS_W:0] dy;
   logic [POS_W:0] adx;
   logic near;
   logic correct;
   logic x_wrap;
   logic y_wrap;
   logic access;
   logic wr;
   logic hit;
   logic [31:0] rd_mux;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   assign en = ctrl_ff[genlock_pkg::CTRL_EN_BIT];
   assign rate = ctrl_ff[genlock_pkg::CTRL_RATE_LSB +: 2];
   // [R5] [R6] [R9] genlock needs same format, framelock a lockable rate
   assign frm_allow = ctrl_ff[genlock_pkg::CTRL_FRAMELOCK_BIT] ?
                      ctrl_ff[genlock_pkg::CTRL_LOCKABLE_BIT] :
                      ctrl_ff[genlock_pkg::CTRL_SAME_FMT_BIT];

   // APB slave, one wait state, write lands at the pready edge
   assign access = psel & penable & ~pready_ff;
   assign wr = psel & penable & pready_ff & pwrite & ~pslverr_ff;

   always_comb begin
      hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         genlock_pkg::CTRL_OFS: rd_mux = 32'(ctrl_ff);
         genlock_pkg::REF_DIV_OFS: rd_mux = 32'(ref_div_ff);
         genlock_pkg::OSC_DIV_OFS: rd_mux = 32'(osc_div_ff);
         genlock_pkg::FRAME_SIZE_OFS: begin
            rd_mux[genlock_pkg::HI_LSB +: 16] = 16'(height_ff);
            rd_mux[15:0] = 16'(width_ff);
         end
         genlock_pkg::SOF_POS_OFS: begin
            rd_mux[genlock_pkg::HI_LSB +: 16] = 16'(sof_y_ff);
            rd_mux[15:0] = 16'(sof_x_ff);
         end
         genlock_pkg::STATUS_OFS: begin
            rd_mux[7:0] = {2'h0, frame_locked, clk_locked, dn_ff, up_ff, state_ff};
         end
         // [R15] extra latency left by the last measured offset
         genlock_pkg::OFFSET_OFS: begin
            rd_mux[genlock_pkg::HI_LSB +: 16] = 16'(offs_y_ff);
            rd_mux[15:0] = 16'(offs_x_ff);
         end
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= access;
         if (access) begin
            pslverr_ff <= ~hit;
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   // [R8] [R11] software-loaded dividers and frame geometry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= genlock_pkg::CTRL_RST;
         ref_div_ff <= DIV_W'(genlock_pkg::REF_DIV_RST);
         osc_div_ff <= DIV_W'(genlock_pkg::OSC_DIV_RST);
         width_ff <= POS_W'(genlock_pkg::WIDTH_RST);
         height_ff <= POS_W'(genlock_pkg::HEIGHT_RST);
         sof_x_ff <= POS_W'(genlock_pkg::SOF_X_RST);
         sof_y_ff <= POS_W'(genlock_pkg::SOF_Y_RST);
      end else if (wr) begin
         case (paddr)
            genlock_pkg::CTRL_OFS:
               ctrl_ff <= genlock_pkg::CTRL_W'(merge(32'(ctrl_ff), pwdata, pstrb));
            genlock_pkg::REF_DIV_OFS:
               ref_div_ff <= DIV_W'(merge(32'(ref_div_ff), pwdata, pstrb));
            genlock_pkg::OSC_DIV_OFS:
               osc_div_ff <= DIV_W'(merge(32'(osc_div_ff), pwdata, pstrb));
            genlock_pkg::FRAME_SIZE_OFS: begin
               width_ff <= POS_W'(merge(32'(width_ff), pwdata, pstrb));
               height_ff <= POS_W'(merge(32'(height_ff), pwdata >> 16, pstrb >> 2));
            end
            genlock_pkg::SOF_POS_OFS: begin
               sof_x_ff <= POS_W'(merge(32'(sof_x_ff), pwdata, pstrb));
               sof_y_ff <= POS_W'(merge(32'(sof_y_ff), pwdata >> 16, pstrb >> 2));
            end
            default: ctrl_ff <= ctrl_ff;
         endcase
      end
   end

   // [R1] fractional divide of the 148.5 MHz oscillator: 1, 1/2 or 2/11
   always_comb begin
      case (rate)
         genlock_pkg::RATE_HALF: begin
            num = genlock_pkg::NUM_HALF;
            den = genlock_pkg::DEN_HALF;
         end
         genlock_pkg::RATE_SD: begin
            num = genlock_pkg::NUM_SD;
            den = genlock_pkg::DEN_SD;
         end
         default: begin
            num = genlock_pkg::NUM_FULL;
            den = genlock_pkg::DEN_FULL;
         end
      endcase
   end

   assign acc_sum = {1'b0, acc_ff} + {1'b0, num};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_ff <= 4'h0;
         vid_en_ff <= 1'b0;
      end else begin
         vid_en_ff <= 1'b0;
         if (mezzanine_clock_input) begin
            if (acc_sum >= {1'b0, den}) begin
               acc_ff <= 4'(acc_sum - {1'b0, den});
               vid_en_ff <= 1'b1;
            end else begin
               acc_ff <= acc_sum[3:0];
            end
         end
      end
   end

   // [R2] divided reference and divided oscillator clocks
   pulse_div #(.W(DIV_W)) u_ref_div (
      .clk(pclk),
      .rst_n(presetn),
      .tick(ref_vid_tick),
      .div(ref_div_ff),
      .pulse(ref_pulse)
   );

   pulse_div #(.W(DIV_W)) u_osc_div (
      .clk(pclk),
      .rst_n(presetn),
      .tick(vid_en_ff),
      .div(osc_div_ff),
      .pulse(osc_pulse)
   );

   // [R3] [R16] up while oscillator lags, down while it leads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_ff <= 1'b0;
         dn_ff <= 1'b0;
      end else if (!en || (ref_pulse && osc_pulse)) begin
         up_ff <= 1'b0;
         dn_ff <= 1'b0;
      end else if (ref_pulse) begin
         up_ff <= ~dn_ff;
         dn_ff <= 1'b0;
      end else if (osc_pulse) begin
         dn_ff <= ~up_ff;
         up_ff <= 1'b0;
      end
   end

   assign good_evt = (ref_pulse & osc_pulse) | (ref_pulse & dn_ff) | (osc_pulse & up_ff);

   // Width of each correction pulse, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_cnt_ff <= 8'h00;
      end else if (!(up_ff | dn_ff) || good_evt) begin
         err_cnt_ff <= 8'h00;
      end else if (err_cnt_ff != 8'hff) begin
         err_cnt_ff <= err_cnt_ff + 8'h01;
      end
   end

   // [R7] clock lock once enough small-error edges follow in a row
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_cnt_ff <= 8'h00;
      end else if (!en || err_cnt_ff > genlock_pkg::CLK_LOCK_ERR_CYC) begin
         lock_cnt_ff <= 8'h00;
      end else if (good_evt && lock_cnt_ff != 8'(LOCK_PULSES)) begin
         lock_cnt_ff <= lock_cnt_ff + 8'h01;
      end
   end

   assign clk_locked = lock_cnt_ff == 8'(LOCK_PULSES);

   // [R10] reference start-of-frame is the rising transition
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_sof_d_ff <= 1'b0;
      end else begin
         ref_sof_d_ff <= ref_sof;
      end
   end

   assign ref_edge = ref_sof & ~ref_sof_d_ff;
   assign frm_active = (state_ff == genlock_pkg::ST_FRM) || (state_ff == genlock_pkg::ST_LOCK);

   // [R12] separation of own position from the start-of-frame point
   assign dx = {1'b0, x_ff} - {1'b0, sof_x_ff};
   assign dy = {1'b0, y_ff} - {1'b0, sof_y_ff};
   assign adx = dx[POS_W] ? (POS_W+1)'(~dx + 1'b1) : dx;
   // [R13] below the oscillator divider value no change is made
   assign near = (dy == '0) && (adx < (POS_W+1)'(osc_div_ff));
   assign correct = ref_edge & frm_active & ~near;

   assign x_wrap = x_ff >= width_ff - POS_W'(1);
   assign y_wrap = y_ff >= height_ff - POS_W'(1);

   // [R11] [R12] raster counters, reloaded at a reference frame start in frame or locked stage when not within the divider threshold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         x_ff <= '0;
         y_ff <= '0;
      end else if (correct) begin
         x_ff <= sof_x_ff;
         y_ff <= sof_y_ff;
      end else if (vid_en_ff) begin
         if (x_wrap) begin
            x_ff <= '0;
            y_ff <= y_wrap ? '0 : y_ff + POS_W'(1);
         end else begin
            x_ff <= x_ff + POS_W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sof_ff <= 1'b0;
         line_ff <= 1'b0;
      end else begin
         sof_ff <= vid_en_ff & (x_ff == sof_x_ff) & (y_ff == sof_y_ff);
         line_ff <= vid_en_ff & (x_ff == '0);
      end
   end

   // [R12] ahead repeats samples, behind removes them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rep_ff <= 1'b0;
         rem_ff <= 1'b0;
         aligned_ff <= 1'b0;
         offs_x_ff <= '0;
         offs_y_ff <= '0;
      end else begin
         rep_ff <= correct & ~dy[POS_W] & ((dy != '0) | ~dx[POS_W]);
         rem_ff <= correct & (dy[POS_W] | ((dy == '0) & dx[POS_W]));
         aligned_ff <= ref_edge & frm_active & near;
         if (ref_edge && frm_active) begin
            offs_x_ff <= dx;
            offs_y_ff <= dy;
         end else if (!en) begin
            offs_x_ff <= '0;
            offs_y_ff <= '0;
         end
      end
   end

   // [R7] [R9] clock stage, then frame stage when rates allow
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         genlock_pkg::ST_IDLE: begin
            if (en) begin
               nxt_state = genlock_pkg::ST_CLK;
            end
         end
         genlock_pkg::ST_CLK: begin
            if (clk_locked && frm_allow) begin
               nxt_state = genlock_pkg::ST_FRM;
            end
         end
         genlock_pkg::ST_FRM: begin
            if (!clk_locked || !frm_allow) begin
               nxt_state = genlock_pkg::ST_CLK;
            end else if (aligned_ff) begin
               nxt_state = genlock_pkg::ST_LOCK;
            end
         end
         genlock_pkg::ST_LOCK: begin
            if (!clk_locked || !frm_allow) begin
               nxt_state = genlock_pkg::ST_CLK;
            end else if (rep_ff || rem_ff) begin
               nxt_state = genlock_pkg::ST_FRM;
            end
         end
         default: nxt_state = genlock_pkg::ST_IDLE;
      endcase
      if (!en) begin
         nxt_state = genlock_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= genlock_pkg::ST_IDLE;
         locked_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         locked_ff <= (nxt_state == genlock_pkg::ST_LOCK);
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign osc_speed_up = up_ff;
   assign osc_slow_down = dn_ff;
   assign out_vid_en = vid_en_ff;
   assign out_sof = sof_ff;
   assign out_line_start = line_ff;
   assign sample_repeat = rep_ff;
   assign sample_remove = rem_ff;
   // [R14] locked: only the frame buffer's field or frame remains
   assign frame_locked = locked_ff;
endmodule
`default_nettype wire

// file: verilog/genlock_pkg.sv
// What this block does
// [R1] Output divider gives 148.5, 74.25, 27 MHz
// [R2] Divide input and output video clocks
// [R3] Detector steers oscillator up/down pins
// [R4] Serial reference clocks run at 148.5 MHz
// [R5] Genlock aligns syncs, same format/rate
// [R6] Framelock aligns start-of-frame only, lockable rate
// [R7] Clock lock first, then frame lock
// [R8] Software programs dividers for equal periods
// [R9] Frame lock only with lockable rates
// [R10] Start-of-frame is a rising transition
// [R11] Start-of-frame position programmable sample/line
// [R12] Measure separation; repeat or remove samples
// [R13] Below divider threshold leave video unchanged
// [R14] Locked latency: one field or frame
// [R15] Unlocked latency grows up to frame
// [R16] Up while lagging, down while leading
package genlock_pkg;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] REF_DIV_OFS = 8'h04;
   localparam logic [7:0] OSC_DIV_OFS = 8'h08;
   localparam logic [7:0] FRAME_SIZE_OFS = 8'h0c;
   localparam logic [7:0] SOF_POS_OFS = 8'h10;
   localparam logic [7:0] STATUS_OFS = 8'h14;
   localparam logic [7:0] OFFSET_OFS = 8'h18;

   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_FRAMELOCK_BIT = 1;
   localparam int CTRL_LOCKABLE_BIT = 2;
   localparam int CTRL_SAME_FMT_BIT = 3;
   localparam int CTRL_RATE_LSB = 4;
   localparam int CTRL_W = 6;
   localparam int HI_LSB = 16;

   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam logic [15:0] REF_DIV_RST = 16'h0010;
   localparam logic [15:0] OSC_DIV_RST = 16'h0010;
   localparam logic [15:0] WIDTH_RST = 16'h0898;
   localparam logic [15:0] HEIGHT_RST = 16'h0465;
   localparam logic [15:0] SOF_X_RST = 16'h0000;
   localparam logic [15:0] SOF_Y_RST = 16'h0000;

   localparam logic [1:0] RATE_FULL = 2'h0;
   localparam logic [1:0] RATE_HALF = 2'h1;
   localparam logic [1:0] RATE_SD = 2'h2;
   localparam logic [3:0] NUM_FULL = 4'h1;
   localparam logic [3:0] DEN_FULL = 4'h1;
   localparam logic [3:0] NUM_HALF = 4'h1;
   localparam logic [3:0] DEN_HALF = 4'h2;
   localparam logic [3:0] NUM_SD = 4'h2;
   localparam logic [3:0] DEN_SD = 4'hb;

   localparam logic [7:0] CLK_LOCK_ERR_CYC = 8'h04;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CLK = 2'b01,
      ST_FRM = 2'b11,
      ST_LOCK = 2'b10
   } lock_state_t;
endpackage

// file: verilog/pulse_div.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_div #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic [W-1:0] div,
   output logic pulse
);
   logic [W-1:0] cnt_ff;
   logic pulse_ff;
   logic last;

   if (W < 2) begin : g_chk
      $error("pulse_div needs W of at least 2");
   end

   // Divide by zero or one passes every tick
   assign last = (div <= W'(1)) || (cnt_ff >= div - W'(1));
   assign pulse = pulse_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
         pulse_ff <= 1'b0;
      end else begin
         pulse_ff <= tick & last;
         if (tick) begin
            if (last) begin
               cnt_ff <= '0;
            end else begin
               cnt_ff <= cnt_ff + W'(1);
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: verif/video_ref_source.sv
`timescale 1ns/1ps
`default_nettype none
module video_ref_source (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic osc_speed_up,
   input wire logic osc_slow_down,
   input wire logic [7:0] ref_step,
   input wire logic sof_en,
   input wire logic [15:0] frame_ticks,
   output logic osc_tick,
   output logic ref_tick,
   output logic ref_sof
);
   logic [7:0] osc_acc_ff;
   logic [7:0] ref_acc_ff;
   logic [15:0] tick_cnt_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {osc_tick, osc_acc_ff} <= 9'h000;
      end else begin
         {osc_tick, osc_acc_ff} <= {1'b0, osc_acc_ff} + (osc_speed_up ? 9'h0a0 : osc_slow_down ? 9'h060 : 9'h080);
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {ref_tick, ref_acc_ff} <= 9'h000;
      end else begin
         {ref_tick, ref_acc_ff} <= {1'b0, ref_acc_ff} + {1'b0, ref_step};
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_ff <= 16'h0000;
         ref_sof <= 1'b0;
      end else begin
         if (ref_tick) begin
            tick_cnt_ff <= (tick_cnt_ff >= frame_ticks - 16'h0001) ? 16'h0000 : tick_cnt_ff + 16'h0001;
         end
         ref_sof <= sof_en && tick_cnt_ff < 16'h0002;
      end
   end
endmodule
`default_nettype wire

// file: verif/video_output_genlock_chk.sv
`timescale 1ns/1ps
`default_nettype none
module video_output_genlock_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic mezzanine_clock_input,
   input wire logic osc_speed_up,
   input wire logic osc_slow_down,
   input wire logic out_vid_en,
   input wire logic out_sof,
   input wire logic sample_repeat,
   input wire logic sample_remove
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   acc_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
      else $error("ready not after one wait state");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   ready_req_a: assert property (pready |-> psel && penable)
      else $error("ready without access");
   steer_excl_a: assert property (!(osc_speed_up && osc_slow_down))
      else $error("speed-up and slow-down together");
   fix_excl_a: assert property (!(sample_repeat && sample_remove))
      else $error("repeat and remove together");
   vid_tick_a: assert property (out_vid_en |-> $past(mezzanine_clock_input))
      else $error("video enable without tick");
   sof_pulse_a: assert property (out_sof |=> !out_sof)
      else $error("start-of-frame pulse too long");
   fix_pulse_a: assert property (sample_repeat || sample_remove |=> !sample_repeat && !sample_remove)
      else $error("correction pulse too long");
endmodule
bind video_output_genlock video_output_genlock_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .mezzanine_clock_input(mezzanine_clock_input),
   .osc_speed_up(osc_speed_up), .osc_slow_down(osc_slow_down), .out_vid_en(out_vid_en),
   .out_sof(out_sof), .sample_repeat(sample_repeat), .sample_remove(sample_remove));
`default_nettype wire

// file: verif/test_video_output_genlock.sv
`timescale 1ns/1ps
`default_nettype none
module test_video_output_genlock;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sof_en = 0, rsof_q = 0;
   logic [7:0] paddr = 8'h00, ref_step = 8'h80;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] pstrb = 4'hf;
   logic [15:0] frame_ticks = 16'h0040;
   logic pready, pslverr, mck, rtk, rsof, up, dn, vid, osof, lstart, rep, rem, frame_locked;
   int err_total = 0, samples_checked = 0;
   int n_up = 0, n_dn = 0, n_vid = 0, n_tick = 0, n_corr = 0, n_osof = 0, n_rsof = 0, n_line = 0, n_rem = 0;
   always #4 pclk = ~pclk;
   video_output_genlock #(.LOCK_PULSES(2)) u_video_output_genlock (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .mezzanine_clock_input(mck), .ref_vid_tick(rtk),
      .ref_sof(rsof), .osc_speed_up(up), .osc_slow_down(dn), .out_vid_en(vid), .out_sof(osof),
      .out_line_start(lstart), .sample_repeat(rep), .sample_remove(rem), .frame_locked(frame_locked));
   video_ref_source u_video_ref_source (.clk(pclk), .rst_n(presetn), .osc_speed_up(up), .osc_slow_down(dn),
      .ref_step(ref_step), .sof_en(sof_en), .frame_ticks(frame_ticks), .osc_tick(mck), .ref_tick(rtk),
      .ref_sof(rsof));
   always @(posedge pclk) begin
      n_up += 32'(up);
      n_dn += 32'(dn);
      n_vid += 32'(vid);
      n_tick += 32'(mck);
      n_corr += 32'(rep | rem);
      n_osof += 32'(osof);
      n_line += 32'(lstart);
      n_rem += 32'(rem);
      n_rsof += 32'(rsof & ~rsof_q);
      rsof_q = rsof;
   end
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic run(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int n;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_total++;
         $display("ERROR %0t: bus timeout", $time);
         tally_and_finish;
      end
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q & m, exp);
   endtask
   task automatic wait_lock;
      int n;
      n = 0;
      while (frame_locked !== 1'b1 && n < 20000) begin
         @(posedge pclk);
         n++;
      end
      chk({31'b0, frame_locked}, 32'h1);
      if (n >= 20000) tally_and_finish;
   endtask
   task automatic t_reset;
      chk(32'({up, dn, vid, osof, rep, rem, frame_locked, pready}), 32'h0);
      rdc(genlock_pkg::CTRL_OFS, '1, 32'h0);
      rdc(genlock_pkg::REF_DIV_OFS, '1, 32'(genlock_pkg::REF_DIV_RST));
      rdc(genlock_pkg::OSC_DIV_OFS, '1, 32'(genlock_pkg::OSC_DIV_RST));
      rdc(genlock_pkg::FRAME_SIZE_OFS, '1, {genlock_pkg::HEIGHT_RST, genlock_pkg::WIDTH_RST});
      rdc(genlock_pkg::SOF_POS_OFS, '1, {genlock_pkg::SOF_Y_RST, genlock_pkg::SOF_X_RST});
   endtask
   task automatic t_regs;
      logic [31:0] q;
      logic e;
      wr(genlock_pkg::SOF_POS_OFS, 32'h0001_0003);
      rdc(genlock_pkg::SOF_POS_OFS, '1, 32'h0001_0003);
      pstrb <= 4'h1;
      wr(genlock_pkg::REF_DIV_OFS, 32'h0000_ffff);
      pstrb <= 4'hf;
      rdc(genlock_pkg::REF_DIV_OFS, '1, 32'h0000_00ff);
      apb(1'b0, 8'h1c, 32'h0, q, e);
      chk({q[30:0], e}, 32'h1);
   endtask
   task automatic t_steer;
      int a, b;
      wr(genlock_pkg::REF_DIV_OFS, 32'h10);
      wr(genlock_pkg::CTRL_OFS, 32'h0);
      ref_step <= 8'h60;
      a = n_up + n_dn;
      run(400);
      chk(32'(n_up + n_dn - a), 32'h0);
      wr(genlock_pkg::CTRL_OFS, 32'h1);
      a = n_dn;
      b = n_up;
      run(400);
      chk(32'((n_dn - a) > (n_up - b)), 32'h1);
      ref_step <= 8'hd0;
      a = n_dn;
      b = n_up;
      run(400);
      chk(32'((n_up - b) > (n_dn - a)), 32'h1);
      ref_step <= 8'h80;
   endtask
   task automatic t_rates;
      logic [3:0] nm[3] = '{genlock_pkg::NUM_FULL, genlock_pkg::NUM_HALF, genlock_pkg::NUM_SD};
      logic [3:0] dn_[3] = '{genlock_pkg::DEN_FULL, genlock_pkg::DEN_HALF, genlock_pkg::DEN_SD};
      int a, b, d;
      for (int r = 0; r < 3; r++) begin
         wr(genlock_pkg::CTRL_OFS, 32'h1 | 32'(r << genlock_pkg::CTRL_RATE_LSB));
         a = n_vid;
         b = n_tick;
         run(440);
         d = (n_vid - a) * int'(dn_[r]) - (n_tick - b) * int'(nm[r]);
         chk(32'(d <= int'(dn_[r]) && d >= -int'(dn_[r])), 32'h1);
      end
   endtask
   task automatic t_frame;
      int a, c, d, e;
      wr(genlock_pkg::FRAME_SIZE_OFS, 32'h0004_0010);
      wr(genlock_pkg::REF_DIV_OFS, 32'h4);
      wr(genlock_pkg::OSC_DIV_OFS, 32'h4);
      sof_en <= 1;
      wr(genlock_pkg::CTRL_OFS, 32'h7);
      wait_lock;
      rdc(genlock_pkg::STATUS_OFS, 32'h33, 32'h32);
      a = n_corr;
      c = n_osof;
      d = n_rsof;
      e = n_line;
      run(640);
      chk(32'(n_corr - a), 32'h0);
      e = (n_line - e) - 4 * (n_rsof - d);
      chk(32'(e <= 4 && e >= -4), 32'h1);
      d = (n_osof - c) - (n_rsof - d);
      chk(32'(d <= 1 && d >= -1), 32'h1);
      a = n_corr;
      c = n_rem;
      wr(genlock_pkg::SOF_POS_OFS, 32'h0002_0008);
      run(1000);
      chk(32'(n_corr > a), 32'h1);
      chk(32'(n_rem > c), 32'h1);
      wr(genlock_pkg::CTRL_OFS, 32'h3);
      run(1000);
      chk({31'b0, frame_locked}, 32'h0);
      wr(genlock_pkg::CTRL_OFS, 32'h9);
      wait_lock;
   endtask
   initial begin
      run(20);
      presetn <= 1;
      @(posedge pclk);
      t_reset;
      t_regs;
      t_steer;
      t_rates;
      t_frame;
      tally_and_finish;
   end
endmodule
`default_nettype wire
